// ### hdl/fcs_pkg.sv
// Constants and types shared by the flash command unit and its host end.
// Assumes one 200 MHz clock and a synchronous active-high reset on both ends.
// Behaviour
// R01: Low program supply refuses program and erase
// R02: FFh enters read array, 50h clears errors
// R03: 90h enters identifier mode until next command; the code keeps identifier mode on 50h
// R04: 70h makes reads return status byte
// R05: Erase is 20h then D0h in block
// R06: Program setup 40h or 10h, then data
// R07: B0h suspends, D0h resumes the operation
// R08: Locked block makes erase or program fail
// R09: Host writes only defined command codes
// R10: Bit 7 ready when one, busy zero
// R11: Bit 6 set while erase suspended
// R12: Bit 5 erase failure; 5 and 4 bad sequence
// R13: Bit 4 set when program fails
// R14: Bit 3 supply low, sampled at operation
// R15: Bit 2 set while program suspended
// R16: Bit 1 lock or protect abort
// R17: Host masks reserved bit 0
// R18: Stay in status mode after erase or program
// R19: Errors set by engine, cleared by 50h only
// R20: Reset enters read array mode
// R21: Read array ignored while engine runs
// R22: Bad second code sets both errors
// R23: Mode register changes only on known commands
package fcs_pkg;
    localparam logic [7:0] CMD_READ_ARRAY  = 8'hff;
    localparam logic [7:0] CMD_READ_ID     = 8'h90;
    localparam logic [7:0] CMD_READ_STATUS = 8'h70;
    localparam logic [7:0] CMD_CLEAR_STAT  = 8'h50;
    localparam logic [7:0] CMD_ERASE_SETUP = 8'h20;
    localparam logic [7:0] CMD_CONFIRM     = 8'hd0;
    localparam logic [7:0] CMD_PROG_SETUP  = 8'h40;
    localparam logic [7:0] CMD_PROG_SETUP2 = 8'h10;
    localparam logic [7:0] CMD_SUSPEND     = 8'hb0;

    localparam int BIT_READY       = 7;
    localparam int BIT_ERASE_PAUSE = 6;
    localparam int BIT_ERASE_ERR   = 5;
    localparam int BIT_PROG_ERR    = 4;
    localparam int BIT_SUPPLY_LOW  = 3;
    localparam int BIT_PROG_PAUSE  = 2;
    localparam int BIT_LOCK_ABORT  = 1;

    localparam int          ADDR_W        = 24;
    localparam logic [23:0] ID_MFR_ADDR   = 24'h000000;
    localparam logic [23:0] ID_DEV_ADDR   = 24'h000001;
    // Arbitrary identity values
    localparam logic [7:0]  ID_MFR_CODE   = 8'h5a;
    localparam logic [7:0]  ID_DEV_CODE   = 8'h3c;
    localparam logic [7:0]  ERASED_BYTE   = 8'hff;
    localparam logic [7:0]  STATUS_RESET  = 8'h80;
    localparam logic [15:0] ERASE_CYCLES  = 16'h0040;
    localparam logic [15:0] PROG_CYCLES   = 16'h0010;

    // Host register offsets on its AXI4-Lite slave
    localparam logic [3:0] REG_CMD    = 4'h0;
    localparam logic [3:0] REG_ADDR   = 4'h4;
    localparam logic [3:0] REG_RDATA  = 4'h8;
    localparam logic [3:0] REG_STATUS = 4'hc;

    typedef enum logic [1:0] {
        FCS_MODE_ARRAY,
        FCS_MODE_ID,
        FCS_MODE_STATUS
    } fcs_mode_t;
endpackage : fcs_pkg

// ### hdl/fcs_if.sv
// Memory-cycle link between the flash command unit and its host.
// A write or read request is a one-cycle strobe; read data return next cycle.
`timescale 1ns/100ps
`default_nettype none
interface fcs_if;
    import fcs_pkg::*;
    logic              wr_stb;
    logic              rd_stb;
    logic [ADDR_W-1:0] addr;
    logic [7:0]        wdata;
    logic [7:0]        rdata;
    logic              rvalid;
    modport device (input wr_stb, rd_stb, addr, wdata, output rdata, rvalid);
    modport host   (output wr_stb, rd_stb, addr, wdata, input rdata, rvalid);
endinterface : fcs_if
`default_nettype wire

// ### hdl/fcs_device.sv
// Flash command interpreter with status byte and a small modelled array.
// Assumes host cycles come from logic on clk_sys; protect inputs are pins.
//
// Local design decisions: the register offsets and register access over AXI4-Lite.
`timescale 1ns/100ps
`default_nettype none
module fcs_device (
    input  wire logic       clk_sys,
    input  wire logic       rst,
    fcs_if.device           link,
    input  wire logic       supply_ok,
    input  wire logic       top_block_protect_n,
    input  wire logic       write_protect_n,
    input  wire logic [7:0] block_lock,
    output logic            engine_busy,
    output logic [7:0]      status_read_data
);
    import fcs_pkg::*;

    typedef enum logic [2:0] {
        FCS_ST_IDLE, FCS_ST_ERASE_2ND, FCS_ST_PROG_2ND
    } fcs_seq_t;
    typedef enum logic [1:0] {
        FCS_OP_NONE, FCS_OP_ERASE, FCS_OP_PROG
    } fcs_op_t;

    logic [7:0]  mem_q [0:255];
    fcs_mode_t   mode_q;
    fcs_seq_t    seq_q;
    fcs_op_t     op_q;
    logic [7:0]  status_q;
    logic [15:0] cnt_q;
    logic [7:0]  op_addr_q;
    logic [7:0]  op_data_q;
    logic        suspend_req_q;
    logic [2:0]  tbp_s_q;
    logic [2:0]  wp_s_q;
    logic [2:0]  sup_s_q;
    logic        tbp_n_q;
    logic        wp_n_q;
    logic        sup_q;
    logic        paused;
    logic        running;
    logic        wr;
    logic [7:0]  cmd;
    logic        start_erase;
    logic        start_prog;
    logic        blocked;

    // Pins pass three flops; change taken once stages 2 and 3 agree
    always_ff @(posedge clk_sys) begin
        tbp_s_q <= {tbp_s_q[1:0], top_block_protect_n};
        wp_s_q  <= {wp_s_q[1:0], write_protect_n};
        sup_s_q <= {sup_s_q[1:0], supply_ok};
        if (rst) begin
            tbp_n_q <= 1'b0;
            wp_n_q  <= 1'b0;
            sup_q   <= 1'b0;
        end else begin
            if (tbp_s_q[2] == tbp_s_q[1]) tbp_n_q <= tbp_s_q[2];
            if (wp_s_q[2] == wp_s_q[1])   wp_n_q  <= wp_s_q[2];
            if (sup_s_q[2] == sup_s_q[1]) sup_q   <= sup_s_q[2];
        end
    end

    assign wr      = link.wr_stb;
    assign cmd     = link.wdata;
    assign paused  = status_q[BIT_ERASE_PAUSE] | status_q[BIT_PROG_PAUSE];
    assign running = (op_q != FCS_OP_NONE) && !paused;
    // Block number taken from the top address bits
    assign start_erase = wr && seq_q == FCS_ST_ERASE_2ND && cmd == CMD_CONFIRM;
    assign start_prog  = wr && seq_q == FCS_ST_PROG_2ND;

    // R08 lock, protect pins and supply checked at start
    always_comb begin
        blocked = block_lock[link.addr[ADDR_W-1 -: 3]]
                | (link.addr[ADDR_W-1 -: 3] == 3'h7 ? !tbp_n_q : !wp_n_q);
    end

    // R23 mode changes on recognised commands only
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            // R20 reset to read array
            mode_q <= FCS_MODE_ARRAY;
        end else if (wr && seq_q != FCS_ST_IDLE) begin
            // R18 status mode after erase or program
            mode_q <= FCS_MODE_STATUS;
        end else if (wr) begin
            case (cmd)
                // R21 read array ignored while running
                CMD_READ_ARRAY:  if (!running) mode_q <= FCS_MODE_ARRAY;
                // R03 identifier mode
                CMD_READ_ID:     mode_q <= FCS_MODE_ID;
                // R04 status mode
                CMD_READ_STATUS, CMD_ERASE_SETUP, CMD_PROG_SETUP, CMD_PROG_SETUP2,
                CMD_SUSPEND, CMD_CONFIRM: mode_q <= FCS_MODE_STATUS;
                default:         mode_q <= mode_q;
            endcase
        end
    end

    // R05 R06 two-cycle sequences
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            seq_q <= FCS_ST_IDLE;
        end else if (wr) begin
            case (seq_q)
                FCS_ST_IDLE: begin
                    if (cmd == CMD_ERASE_SETUP && op_q == FCS_OP_NONE)
                        seq_q <= FCS_ST_ERASE_2ND;
                    else if ((cmd == CMD_PROG_SETUP || cmd == CMD_PROG_SETUP2)
                             && (op_q == FCS_OP_NONE))
                        seq_q <= FCS_ST_PROG_2ND;
                end
                default: seq_q <= FCS_ST_IDLE;
            endcase
        end
    end

    // Engine: op, counter, target, status byte
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            op_q          <= FCS_OP_NONE;
            cnt_q         <= 16'h0000;
            op_addr_q     <= 8'h00;
            op_data_q     <= 8'h00;
            suspend_req_q <= 1'b0;
            status_q      <= STATUS_RESET;
        end else begin
            if (start_erase || start_prog) begin
                // R01 R14 R16 refuse on low supply or lock
                if (!sup_q || blocked) begin
                    // R19 an abort never clears an earlier flag
                    status_q[BIT_SUPPLY_LOW] <= status_q[BIT_SUPPLY_LOW] | !sup_q;
                    status_q[BIT_LOCK_ABORT] <= status_q[BIT_LOCK_ABORT] | blocked;
                    if (start_erase) status_q[BIT_ERASE_ERR] <= 1'b1;
                    else             status_q[BIT_PROG_ERR]  <= 1'b1;
                end else begin
                    op_q                <= start_erase ? FCS_OP_ERASE : FCS_OP_PROG;
                    cnt_q               <= start_erase ? ERASE_CYCLES : PROG_CYCLES;
                    op_addr_q           <= link.addr[7:0];
                    op_data_q           <= cmd;
                    // R10 busy while engine runs
                    status_q[BIT_READY] <= 1'b0;
                end
            end else if (wr && seq_q == FCS_ST_ERASE_2ND) begin
                // R22 R12 bad confirm sets both errors
                status_q[BIT_ERASE_ERR] <= 1'b1;
                status_q[BIT_PROG_ERR]  <= 1'b1;
            end else if (wr && cmd == CMD_CLEAR_STAT && seq_q == FCS_ST_IDLE) begin
                // R02 R19 only this command clears errors
                status_q[BIT_ERASE_ERR:BIT_SUPPLY_LOW] <= 3'b000;
                status_q[BIT_LOCK_ABORT]               <= 1'b0;
            end else if (wr && cmd == CMD_SUSPEND && running) begin
                // R07 suspend request
                suspend_req_q <= 1'b1;
            end else if (wr && cmd == CMD_CONFIRM && paused) begin
                // R07 resume; R11 R15 pause flags drop
                status_q[BIT_ERASE_PAUSE] <= 1'b0;
                status_q[BIT_PROG_PAUSE]  <= 1'b0;
                status_q[BIT_READY]       <= 1'b0;
            end else if (running) begin
                if (suspend_req_q) begin
                    // R11 R15 suspended: ready with pause flag
                    suspend_req_q       <= 1'b0;
                    status_q[BIT_READY] <= 1'b1;
                    if (op_q == FCS_OP_ERASE) status_q[BIT_ERASE_PAUSE] <= 1'b1;
                    else                      status_q[BIT_PROG_PAUSE]  <= 1'b1;
                end else if (cnt_q == 16'h0001) begin
                    op_q                <= FCS_OP_NONE;
                    cnt_q               <= 16'h0000;
                    status_q[BIT_READY] <= 1'b1;
                    // R13 R12 program only clears bits, a 0-to-1 fails
                    if (op_q == FCS_OP_PROG && (op_data_q & ~mem_q[op_addr_q]) != 8'h00)
                        status_q[BIT_PROG_ERR] <= 1'b1;
                end else begin
                    cnt_q <= cnt_q - 16'h0001;
                end
            end
        end
    end

    // Array written when a running operation's count is 1 and no suspend is pending, a failed program included
    always_ff @(posedge clk_sys) begin
        if (running && !suspend_req_q && cnt_q == 16'h0001) begin
            if (op_q == FCS_OP_ERASE) mem_q[op_addr_q] <= ERASED_BYTE;
            else mem_q[op_addr_q] <= mem_q[op_addr_q] & op_data_q;
        end
    end

    // Read answers by mode, one cycle after the strobe
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            link.rvalid      <= 1'b0;
            link.rdata       <= 8'h00;
            engine_busy      <= 1'b0;
            status_read_data <= STATUS_RESET;
        end else begin
            link.rvalid      <= link.rd_stb;
            engine_busy      <= running;
            status_read_data <= status_q;
            if (link.rd_stb) begin
                case (mode_q)
                    FCS_MODE_ARRAY:  link.rdata <= mem_q[link.addr[7:0]];
                    FCS_MODE_ID:     link.rdata <= (link.addr == ID_MFR_ADDR) ? ID_MFR_CODE
                                        : (link.addr == ID_DEV_ADDR) ? ID_DEV_CODE : 8'h00;
                    default:         link.rdata <= status_q;
                endcase
            end
        end
    end
endmodule : fcs_device
`default_nettype wire

// ### hdl/fcs_host.sv
// Host end: AXI4-Lite slave turning register writes into link cycles.
// Assumes the device answers reads one cycle after the read strobe.
`timescale 1ns/100ps
`default_nettype none
module fcs_host (
    input  wire logic        clk_sys,
    input  wire logic        rst,
    fcs_if.host              link,
    input  wire logic [31:0] s_awaddr,
    input  wire logic        s_awvalid,
    output logic             s_awready,
    input  wire logic [31:0] s_wdata,
    input  wire logic [3:0]  s_wstrb,
    input  wire logic        s_wvalid,
    output logic             s_wready,
    output logic [1:0]       s_bresp,
    output logic             s_bvalid,
    input  wire logic        s_bready,
    input  wire logic [31:0] s_araddr,
    input  wire logic        s_arvalid,
    output logic             s_arready,
    output logic [31:0]      s_rdata,
    output logic [1:0]       s_rresp,
    output logic             s_rvalid,
    input  wire logic        s_rready
);
    import fcs_pkg::*;

    logic [3:0]        awa_q;
    logic              aw_q;
    logic [7:0]        wd_q;
    logic              w_q;
    logic [ADDR_W-1:0] addr_q;
    logic [7:0]        rd_q;
    logic              busy_q;

    // Offsets beyond the register window fold onto an unmapped one
    function automatic logic [3:0] reg_sel(input logic [31:0] a);
        reg_sel = (|a[31:4]) ? 4'hf : a[3:0];
    endfunction : reg_sel

    // Write: take address and data in either order, then act
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            aw_q <= 1'b0; w_q <= 1'b0; awa_q <= 4'h0; wd_q <= 8'h00;
            s_awready <= 1'b1; s_wready <= 1'b1; s_bvalid <= 1'b0;
            s_bresp <= 2'b00; addr_q <= '0;
            link.wr_stb <= 1'b0; link.rd_stb <= 1'b0; link.addr <= '0;
            link.wdata <= 8'h00; rd_q <= 8'h00; busy_q <= 1'b0;
        end else begin
            link.wr_stb <= 1'b0;
            link.rd_stb <= 1'b0;
            if (s_awvalid && s_awready) begin
                aw_q <= 1'b1; awa_q <= reg_sel(s_awaddr); s_awready <= 1'b0;
            end
            if (s_wvalid && s_wready) begin
                w_q <= 1'b1; wd_q <= s_wdata[7:0]; s_wready <= 1'b0;
            end
            if (aw_q && w_q && !s_bvalid) begin
                aw_q <= 1'b0; w_q <= 1'b0;
                s_bvalid <= 1'b1;
                s_bresp  <= 2'b00;
                case (awa_q)
                    // R09 software supplies only defined codes
                    REG_CMD: begin
                        link.wr_stb <= 1'b1;
                        link.addr   <= addr_q;
                        link.wdata  <= wd_q;
                    end
                    REG_ADDR: addr_q <= {wd_q, addr_q[ADDR_W-1:8]};
                    REG_RDATA: begin
                        link.rd_stb <= 1'b1;
                        link.addr   <= addr_q;
                        busy_q      <= 1'b1;
                    end
                    REG_STATUS: ;
                    default: s_bresp <= 2'b10;
                endcase
            end
            if (s_bvalid && s_bready) begin
                s_bvalid <= 1'b0; s_awready <= 1'b1; s_wready <= 1'b1;
            end
            if (link.rvalid) begin
                // R17 reserved bit masked
                rd_q   <= link.rdata & 8'hfe;
                busy_q <= 1'b0;
            end
        end
    end

    // Read: registers return address, captured byte or busy flag
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            s_arready <= 1'b1; s_rvalid <= 1'b0; s_rdata <= 32'h0; s_rresp <= 2'b00;
        end else if (s_arvalid && s_arready) begin
            s_arready <= 1'b0;
            s_rvalid  <= 1'b1;
            s_rresp   <= 2'b00;
            case (reg_sel(s_araddr))
                REG_ADDR:   s_rdata <= {8'h00, addr_q};
                REG_RDATA:  s_rdata <= {24'h0, rd_q};
                REG_STATUS: s_rdata <= {31'h0, busy_q};
                REG_CMD:    s_rdata <= 32'h0;
                default: begin
                    s_rdata <= 32'h0;
                    s_rresp <= 2'b10;
                end
            endcase
        end else if (s_rvalid && s_rready) begin
            s_rvalid  <= 1'b0;
            s_arready <= 1'b1;
        end
    end
endmodule : fcs_host
`default_nettype wire

// ### sim/fcs_chk.sv
// Assertions on the link between the host end and the flash command unit.
// Assumes the link signals are wired in directly; one clock, sync reset.
`timescale 1ns/100ps
`default_nettype none
module fcs_chk (
    input wire logic                       clk_sys,
    input wire logic                       rst,
    input wire logic                       wr_stb,
    input wire logic                       rd_stb,
    input wire logic [fcs_pkg::ADDR_W-1:0] addr,
    input wire logic [7:0]                 wdata,
    input wire logic [7:0]                 rdata,
    input wire logic                       rvalid
);
    import fcs_pkg::*;
    logic second_q, id_q, stat_q, clean_q;
    logic setup_w;
    assign setup_w = wdata == CMD_ERASE_SETUP || wdata == CMD_PROG_SETUP
                     || wdata == CMD_PROG_SETUP2;
    // Mode shadow seen from the link; a skipped case only loses checks
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            second_q <= 1'b0;
            id_q     <= 1'b0;
            stat_q   <= 1'b0;
            clean_q  <= 1'b0;
        end else if (wr_stb) begin
            second_q <= !second_q && setup_w;
            id_q     <= !second_q && wdata == CMD_READ_ID;
            if (second_q || wdata != CMD_CLEAR_STAT) begin
                stat_q <= second_q || !(wdata == CMD_READ_ARRAY || wdata == CMD_READ_ID);
            end
            clean_q  <= !second_q && (wdata == CMD_CLEAR_STAT
                        || clean_q && wdata != CMD_CONFIRM);
        end
    end
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (rst);
    sequence s_id_rd(logic [23:0] a);
        rd_stb && id_q && addr == a;
    endsequence
    sequence s_clean_rd;
        rd_stb && stat_q && clean_q ##1 rvalid && rdata[BIT_READY];
    endsequence
    a_read_answer:
        assert property (rd_stb |=> rvalid) else $error("read strobe not answered");
    a_answer_cause:
        assert property (rvalid |-> $past(rd_stb)) else $error("answer without read");
    a_write_single:
        assert property (wr_stb |=> !wr_stb) else $error("write strobe too long");
    a_quiet_reset:
        assert property ($fell(rst) |-> !wr_stb && !rd_stb && !rvalid)
        else $error("link busy after reset");
    a_rdata_hold:
        assert property (!$past(rst) && !rvalid |-> $stable(rdata))
        else $error("read data moved without a read");
    a_id_maker:
        assert property (s_id_rd(ID_MFR_ADDR) |=> rdata == ID_MFR_CODE)
        else $error("wrong maker code");
    a_id_device:
        assert property (s_id_rd(ID_DEV_ADDR) |=> rdata == ID_DEV_CODE)
        else $error("wrong device code");
    a_id_other:
        assert property (rd_stb && id_q && addr > ID_DEV_ADDR |=> rdata == 8'h00)
        else $error("id read elsewhere not zero");
    a_clear_holds:
        assert property (s_clean_rd |-> (rdata & 8'h3a) == 8'h00)
        else $error("error flag set without an operation");
endmodule : fcs_chk
`default_nettype wire

// ### sim/flash_command_status_unit_test.sv
// Testbench: AXI4-Lite tasks drive the host end, device pins driven here.
// Assumes both ends meet in fcs_if, with the checker beside the link.
`timescale 1ns/100ps
`default_nettype none
module flash_command_status_unit_test;
    import fcs_pkg::*;
    logic        clk_sys = 1'b0, rst = 1'b1;
    logic        supply_ok = 1'b1, top_block_protect_n = 1'b1, write_protect_n = 1'b1;
    logic [7:0]  block_lock = 8'h00;
    logic        engine_busy;
    logic [7:0]  status_read_data;
    logic [31:0] s_awaddr = '0, s_wdata = '0, s_araddr = '0, s_rdata;
    logic [3:0]  s_wstrb = 4'hf;
    logic        s_awvalid = 0, s_wvalid = 0, s_bready = 0, s_arvalid = 0, s_rready = 0;
    logic        s_awready, s_wready, s_bvalid, s_arready, s_rvalid;
    logic [1:0]  s_bresp, s_rresp;
    int          n_errors = 0, n_tests = 0;
    always #2.5 clk_sys = ~clk_sys;
    fcs_if link ();
    fcs_device u_fcs_device (.clk_sys(clk_sys), .rst(rst), .link(link), .supply_ok(supply_ok),
        .top_block_protect_n(top_block_protect_n), .write_protect_n(write_protect_n),
        .block_lock(block_lock), .engine_busy(engine_busy),
        .status_read_data(status_read_data));
    fcs_host u_fcs_host (.clk_sys(clk_sys), .rst(rst), .link(link), .s_awaddr(s_awaddr),
        .s_awvalid(s_awvalid), .s_awready(s_awready), .s_wdata(s_wdata), .s_wstrb(s_wstrb),
        .s_wvalid(s_wvalid), .s_wready(s_wready), .s_bresp(s_bresp), .s_bvalid(s_bvalid),
        .s_bready(s_bready), .s_araddr(s_araddr), .s_arvalid(s_arvalid),
        .s_arready(s_arready), .s_rdata(s_rdata), .s_rresp(s_rresp), .s_rvalid(s_rvalid),
        .s_rready(s_rready));
    fcs_chk u_fcs_chk (.clk_sys(clk_sys), .rst(rst), .wr_stb(link.wr_stb),
        .rd_stb(link.rd_stb), .addr(link.addr), .wdata(link.wdata), .rdata(link.rdata),
        .rvalid(link.rvalid));
    task automatic end_sim;
        $display("comparisons %0d mismatches %0d", n_tests, n_errors);
        if (n_errors == 0 && n_tests > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask : end_sim
    task automatic hang(input string what);
        n_errors++;
        $display("BAD %s expected answer seen none", what);
        end_sim();
    endtask : hang
    task automatic check8(input string what, input logic [7:0] exp, input logic [7:0] got);
        n_tests++;
        if (got !== exp) begin
            n_errors++;
            $display("BAD %s expected %h seen %h", what, exp, got);
        end
    endtask : check8
    task automatic axi_wr(input logic [31:0] a, input logic [31:0] d, output logic [1:0] r);
        int i;
        @(posedge clk_sys);
        s_awaddr  <= a;
        s_wdata   <= d;
        s_awvalid <= 1'b1;
        s_wvalid  <= 1'b1;
        s_bready  <= 1'b1;
        for (i = 0; i < 50; i++) begin
            @(posedge clk_sys);
            if (s_awvalid && s_awready) s_awvalid <= 1'b0;
            if (s_wvalid && s_wready) s_wvalid <= 1'b0;
            if (s_bvalid === 1'b1) begin
                r = s_bresp;
                s_bready <= 1'b0;
                break;
            end
        end
        if (i == 50) hang("write answer");
    endtask : axi_wr
    task automatic axi_rd(input logic [31:0] a, output logic [31:0] d, output logic [1:0] r);
        int i;
        @(posedge clk_sys);
        s_araddr  <= a;
        s_arvalid <= 1'b1;
        s_rready  <= 1'b1;
        for (i = 0; i < 50; i++) begin
            @(posedge clk_sys);
            if (s_arvalid && s_arready) s_arvalid <= 1'b0;
            if (s_rvalid === 1'b1) begin
                d = s_rdata;
                r = s_rresp;
                s_rready <= 1'b0;
                break;
            end
        end
        if (i == 50) hang("read answer");
    endtask : axi_rd
    task automatic cmd(input logic [7:0] b);
        logic [1:0] r;
        axi_wr(32'(REG_CMD), {24'h0, b}, r);
    endtask : cmd
    task automatic set_addr(input logic [23:0] a);
        logic [1:0] r;
        for (int k = 0; k < 3; k++) axi_wr(32'(REG_ADDR), {24'h0, a[8*k +: 8]}, r);
    endtask : set_addr
    task automatic rd_chk(input string what, input logic [7:0] exp, input logic [7:0] m = 8'hfe);
        logic [31:0] d;
        logic [1:0]  r;
        int          i;
        axi_wr(32'(REG_RDATA), 32'h0, r);
        for (i = 0; i < 20; i++) begin
            axi_rd(32'(REG_STATUS), d, r);
            if (d[0] === 1'b0) break;
        end
        if (i == 20) hang("link read");
        axi_rd(32'(REG_RDATA), d, r);
        check8(what, exp & m, d[7:0] & m);
    endtask : rd_chk
    task automatic wait_ready;
        logic [31:0] d;
        logic [1:0]  r;
        for (int i = 0; i < 40; i++) begin
            axi_wr(32'(REG_RDATA), 32'h0, r);
            repeat (4) @(posedge clk_sys);
            axi_rd(32'(REG_RDATA), d, r);
            if (d[BIT_READY] === 1'b1) return;
        end
        hang("engine ready");
    endtask : wait_ready
    task automatic t_reset;
        logic [31:0] d;
        logic [1:0]  r;
        cmd(CMD_READ_STATUS);
        rd_chk("status after reset", STATUS_RESET);
        check8("status pins", STATUS_RESET, status_read_data);
        axi_wr(32'h10, 32'h0, r);
        check8("unmapped write", 8'h02, {6'h0, r});
        axi_rd(32'h10, d, r);
        check8("unmapped read", 8'h02, {6'h0, r});
        $display("test reset done");
    endtask : t_reset
    task automatic t_id;
        cmd(CMD_READ_ID);
        set_addr(ID_MFR_ADDR);
        rd_chk("maker code", ID_MFR_CODE);
        set_addr(ID_DEV_ADDR);
        rd_chk("device code", ID_DEV_CODE);
        set_addr(24'h000002);
        rd_chk("other id place", 8'h00);
        cmd(CMD_READ_STATUS);
        set_addr(ID_MFR_ADDR);
        rd_chk("status leaves id", STATUS_RESET);
        $display("test identifier done");
    endtask : t_id
    task automatic t_erase_prog;
        set_addr(24'h000020);
        cmd(CMD_ERASE_SETUP);
        cmd(CMD_CONFIRM);
        rd_chk("erase busy", 8'h00, 8'h80);
        check8("busy pin", 8'h01, {7'h0, engine_busy});
        cmd(CMD_READ_ARRAY);
        rd_chk("array while busy", 8'h00, 8'h80);
        wait_ready();
        rd_chk("erase done", 8'h80);
        check8("idle pin", 8'h00, {7'h0, engine_busy});
        cmd(CMD_READ_ARRAY);
        rd_chk("erased byte", ERASED_BYTE);
        for (int k = 0; k < 2; k++) begin
            cmd(k ? CMD_PROG_SETUP2 : CMD_PROG_SETUP);
            cmd(k ? 8'h24 : 8'ha4);
            wait_ready();
            rd_chk("program done", 8'h80);
            cmd(CMD_READ_ARRAY);
            rd_chk("programmed byte", k ? 8'h24 : 8'ha4);
        end
        cmd(CMD_PROG_SETUP);
        cmd(8'hff);
        wait_ready();
        rd_chk("program fail", 8'h90);
        cmd(CMD_CLEAR_STAT);
        rd_chk("after clear", 8'h80);
        $display("test erase program done");
    endtask : t_erase_prog
    task automatic t_suspend;
        cmd(CMD_ERASE_SETUP);
        cmd(CMD_CONFIRM);
        cmd(CMD_SUSPEND);
        wait_ready();
        rd_chk("erase paused", 8'hc0);
        check8("paused pins", 8'hc0, status_read_data);
        cmd(CMD_CONFIRM);
        rd_chk("erase resumed", 8'h00, 8'hc0);
        wait_ready();
        rd_chk("erase finished", 8'h80);
        cmd(CMD_PROG_SETUP);
        cmd(8'h00);
        cmd(CMD_SUSPEND);
        wait_ready();
        rd_chk("program paused", 8'h84);
        cmd(CMD_CONFIRM);
        wait_ready();
        rd_chk("program finished", 8'h80);
        $display("test suspend done");
    endtask : t_suspend
    task automatic t_protect;
        logic [23:0] a [4] = '{24'h200000, 24'he00000, 24'h000040, 24'h000040};
        logic [7:0]  e [4] = '{8'ha2, 8'h92, 8'ha2, 8'h98};
        for (int k = 0; k < 4; k++) begin
            block_lock          <= (k == 0) ? 8'h02 : 8'h00;
            top_block_protect_n <= (k != 1);
            write_protect_n     <= (k != 2);
            supply_ok           <= (k != 3);
            set_addr(a[k]);
            cmd(k[0] ? CMD_PROG_SETUP : CMD_ERASE_SETUP);
            cmd(k[0] ? 8'h00 : CMD_CONFIRM);
            rd_chk("refused operation", e[k]);
            block_lock          <= 8'h00;
            top_block_protect_n <= 1'b1;
            write_protect_n     <= 1'b1;
            supply_ok           <= 1'b1;
            cmd(CMD_READ_STATUS);
            rd_chk("flags kept", e[k]);
            cmd(CMD_CLEAR_STAT);
            rd_chk("flags cleared", 8'h80);
        end
        cmd(CMD_ERASE_SETUP);
        cmd(CMD_READ_STATUS);
        rd_chk("bad sequence", 8'hb0);
        cmd(CMD_CLEAR_STAT);
        rd_chk("sequence cleared", 8'h80);
        $display("test protect done");
    endtask : t_protect
    initial begin
        // Pin filters settle in the wait after reset
        repeat (2) @(posedge clk_sys);
        rst <= 1'b0;
        repeat (4) @(posedge clk_sys);
        t_reset();
        t_id();
        t_erase_prog();
        t_suspend();
        t_protect();
        end_sim();
    end
endmodule : flash_command_status_unit_test
`default_nettype wire
